// >>> rtl/mcrb_pkg.sv
// Constants, field layout and reset values of the misc control register bank
package mcrb_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PIN_CFG_OFS   = 8'h68;
  localparam logic [7:0] WDOG_OFS      = 8'h69;
  localparam logic [7:0] BATT_THR_OFS  = 8'h6A;
  localparam logic [7:0] DISCH_OFS     = 8'h6B;
  localparam logic [7:0] LAMP_PER_OFS  = 8'h6C;

  // ==========================================================================
  // Field positions
  localparam int PIN_SET_BIT   = 0;
  localparam int PIN_STS_BIT   = 1;
  localparam int PIN_DIR_BIT   = 2;
  localparam int PIN_PDEN_BIT  = 3;
  localparam int PIN_DEB_BIT   = 4;
  localparam int PIN_SEL_BIT   = 5;
  localparam int WDOG_MODE_BIT = 3;
  localparam int WDOG_TIME_LSB = 0;
  localparam int THR_LSB       = 1;
  localparam int DISCH_DEB_BIT = 0;
  localparam int LAMP1_LSB     = 0;
  localparam int LAMP2_LSB     = 3;

  // ==========================================================================
  // Reset values
  localparam logic       PIN_SET_RST   = 1'h0;
  localparam logic       PIN_DIR_RST   = 1'h0;
  localparam logic       PIN_PDEN_RST  = 1'h1;
  localparam logic       PIN_DEB_RST   = 1'h0;
  localparam logic       PIN_SEL_RST   = 1'h0;
  localparam logic       PIN_STS_RST   = 1'h1;
  localparam logic       DISCH_FLG_RST = 1'h0;
  localparam logic       WDOG_MODE_RST = 1'h0;
  localparam logic [2:0] WDOG_TIME_RST = 3'h0;
  localparam logic [4:0] THR_RST       = 5'h00;
  localparam logic       DISCH_DEB_RST = 1'h0;
  localparam logic [2:0] LAMP_PER_RST  = 3'h0;

  // ==========================================================================
  // Timing: the clock period and the two sampling rates
  localparam int CLK_PERIOD_NS    = 4;
  localparam int SHORT_RATE_NS    = 30500;
  localparam int LONG_RATE_MS     = 50;
  localparam int MS_NS            = 1000000;
  localparam int DEB_SAMPLES      = 3;
  localparam int SHORT_TICK_CYC   = SHORT_RATE_NS / CLK_PERIOD_NS;
  localparam int MS_TICK_CYC      = MS_NS / CLK_PERIOD_NS;
  localparam int LAMP_BASE_MS     = 125;
  localparam int THR_BASE_MV      = 2500;
  localparam int THR_STEP_MV      = 50;
  localparam int THR_MAX_MV       = 3500;
  localparam logic [4:0] THR_LOW_CODE = 5'h04;

  // Watchdog timeout in milliseconds per code, 0 means disabled
  function automatic logic [16:0] wdog_ms(input logic [2:0] code);
    case (code)
      3'h1:    wdog_ms = 17'd5000;
      3'h2:    wdog_ms = 17'd10000;
      3'h3:    wdog_ms = 17'd20000;
      3'h4:    wdog_ms = 17'd40000;
      3'h5:    wdog_ms = 17'd60000;
      3'h6:    wdog_ms = 17'd80000;
      3'h7:    wdog_ms = 17'd100000;
      default: wdog_ms = 17'd0;
    endcase
  endfunction

  // Lamp period in milliseconds, doubling per code
  function automatic logic [12:0] lamp_ms(input logic [2:0] code);
    lamp_ms = (code == 3'h0) ? 13'd0 : 13'(LAMP_BASE_MS << (code - 3'h1));
  endfunction

  // Comparator threshold in millivolts, 0 for bypass
  function automatic logic [11:0] thr_mv(input logic [4:0] code);
    logic [11:0] mv;
    mv = 12'(THR_BASE_MV + THR_STEP_MV * (int'(code) - int'(THR_LOW_CODE)));
    if (code == 5'h00)
      thr_mv = 12'd0;
    else if (code <= THR_LOW_CODE)
      thr_mv = 12'(THR_BASE_MV);
    else if (mv > 12'(THR_MAX_MV))
      thr_mv = 12'(THR_MAX_MV);
    else
      thr_mv = mv;
  endfunction
endpackage

// >>> rtl/mcrb_debounce.sv
// Three-sample input debouncer with a sampling enable
`timescale 1ns/1ps
module mcrb_debounce #(
  parameter logic RESET_VAL = 1'h1
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  // Sampling
  input  wire logic sample_en_in,
  input  wire logic level_in,
  // Debounced level
  output logic      level_out
);
  logic [2:0] hist_reg;
  logic       level_reg;
  wire        all_high = &hist_reg;
  wire        all_low  = ~|hist_reg;

  // ==========================================================================
  // History and output
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      hist_reg  <= {3{RESET_VAL}};
      level_reg <= RESET_VAL;
    end else if (sample_en_in) begin
      hist_reg <= {hist_reg[1:0], level_in};
    end else if (all_high || all_low) begin
      // Change only after three equal samples
      level_reg <= hist_reg[0];
    end
  end

  assign level_out = level_reg;
endmodule // mcrb_debounce

// >>> rtl/mcrb_top.sv
// Misc control register bank: pin, watchdog, comparators and lamp periods
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module mcrb_top #(
  parameter int SHORT_TICK_CYC = mcrb_pkg::SHORT_TICK_CYC,
  parameter int MS_TICK_CYC    = mcrb_pkg::MS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // Boot configuration
  input  wire logic [2:0]  boot_wdog_time_in,
  input  wire logic [4:0]  boot_batt_thr_in,
  // Pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_out,
  output logic             pin_pulldown_enable_out,
  input  wire logic        pwm_in,
  // Watchdog
  input  wire logic        wdog_irq_clear_in,
  input  wire logic        any_irq_pending_in,
  output logic             wdog_irq_out,
  output logic             watchdog_shutdown_out,
  // Comparators
  input  wire logic        discharge_raw_in,
  output logic      [11:0] batt_thr_mv_out,
  output logic      [11:0] disch_thr_mv_out,
  output logic             discharge_below_out,
  // Lamps
  output logic      [1:0]  lamp_period_tick_out
);
  // ==========================================================================
  // Registers
  logic        boot_done_reg;
  logic        pin_set_reg, pin_dir_reg, pin_pden_reg, pin_debounce_select_reg, pin_sel_reg;
  logic        watchdog_mode_select_reg;
  logic [2:0]  watchdog_timeout_select_reg;
  logic [4:0]  battery_threshold_code_reg, discharge_threshold_code_reg;
  logic        discharge_debounce_select_reg;
  logic [2:0]  lamp_one_period_reg, lamp_two_period_reg;
  logic [7:0]  rdata_reg;
  logic [31:0] short_cnt_reg, ms_cnt_reg;
  logic [5:0]  long_cnt_reg;
  logic        short_tick_reg, ms_tick_reg, long_tick_reg;
  logic [16:0] wdog_cnt_reg;
  logic        wdog_irq_reg, shutdown_reg;
  logic [12:0] lamp_cnt_reg [2];
  logic [1:0]  lamp_tick_reg;
  logic        disch_reg;
  logic [7:0]  rdata_next;

  // ==========================================================================
  // Decode
  wire wr_pin   = wr_in && (addr_in == mcrb_pkg::PIN_CFG_OFS);
  wire wr_wdog  = wr_in && (addr_in == mcrb_pkg::WDOG_OFS);
  wire wr_batt  = wr_in && (addr_in == mcrb_pkg::BATT_THR_OFS);
  wire wr_disch = wr_in && (addr_in == mcrb_pkg::DISCH_OFS);
  wire wr_lamp  = wr_in && (addr_in == mcrb_pkg::LAMP_PER_OFS);

  wire [1:0] deb_level;
  wire [1:0] deb_raw = {discharge_raw_in, pin_in};
  wire [1:0] deb_sel = {discharge_debounce_select_reg, pin_debounce_select_reg};
  wire       pin_sts = deb_level[0];

  always_comb begin
    rdata_next = 8'h00;
    case (addr_in)
      mcrb_pkg::PIN_CFG_OFS: begin
        rdata_next[mcrb_pkg::PIN_SET_BIT]  = pin_set_reg;
        rdata_next[mcrb_pkg::PIN_STS_BIT]  = pin_sts;
        rdata_next[mcrb_pkg::PIN_DIR_BIT]  = pin_dir_reg;
        rdata_next[mcrb_pkg::PIN_PDEN_BIT] = pin_pden_reg;
        rdata_next[mcrb_pkg::PIN_DEB_BIT]  = pin_debounce_select_reg;
        rdata_next[mcrb_pkg::PIN_SEL_BIT]  = pin_sel_reg;
      end
      mcrb_pkg::WDOG_OFS: begin
        rdata_next[mcrb_pkg::WDOG_MODE_BIT]        = watchdog_mode_select_reg;
        rdata_next[mcrb_pkg::WDOG_TIME_LSB +: 3]   = watchdog_timeout_select_reg;
      end
      mcrb_pkg::BATT_THR_OFS: rdata_next[mcrb_pkg::THR_LSB +: 5] = battery_threshold_code_reg;
      mcrb_pkg::DISCH_OFS: begin
        rdata_next[mcrb_pkg::THR_LSB +: 5]       = discharge_threshold_code_reg;
        rdata_next[mcrb_pkg::DISCH_DEB_BIT]      = discharge_debounce_select_reg;
      end
      mcrb_pkg::LAMP_PER_OFS: begin
        rdata_next[mcrb_pkg::LAMP1_LSB +: 3] = lamp_one_period_reg;
        rdata_next[mcrb_pkg::LAMP2_LSB +: 3] = lamp_two_period_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  // ==========================================================================
  // Register file
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      boot_done_reg                 <= 1'b0;
      pin_set_reg                   <= mcrb_pkg::PIN_SET_RST;
      pin_dir_reg                   <= mcrb_pkg::PIN_DIR_RST;
      pin_pden_reg                  <= mcrb_pkg::PIN_PDEN_RST;
      pin_debounce_select_reg       <= mcrb_pkg::PIN_DEB_RST;
      pin_sel_reg                   <= mcrb_pkg::PIN_SEL_RST;
      watchdog_mode_select_reg      <= mcrb_pkg::WDOG_MODE_RST;
      watchdog_timeout_select_reg   <= mcrb_pkg::WDOG_TIME_RST;
      battery_threshold_code_reg    <= mcrb_pkg::THR_RST;
      discharge_threshold_code_reg  <= mcrb_pkg::THR_RST;
      discharge_debounce_select_reg <= mcrb_pkg::DISCH_DEB_RST;
      lamp_one_period_reg           <= mcrb_pkg::LAMP_PER_RST;
      lamp_two_period_reg           <= mcrb_pkg::LAMP_PER_RST;
      rdata_reg                     <= 8'h00;
    end else begin
      rdata_reg <= rd_in ? rdata_next : 8'h00;
      if (!boot_done_reg) begin
        // Boot straps are caught once, just after reset release
        boot_done_reg               <= 1'b1;
        watchdog_timeout_select_reg <= boot_wdog_time_in;
        battery_threshold_code_reg  <= boot_batt_thr_in;
      end
      if (wr_pin) begin
        pin_set_reg             <= wdata_in[mcrb_pkg::PIN_SET_BIT];
        pin_dir_reg             <= wdata_in[mcrb_pkg::PIN_DIR_BIT];
        pin_pden_reg            <= wdata_in[mcrb_pkg::PIN_PDEN_BIT];
        pin_debounce_select_reg <= wdata_in[mcrb_pkg::PIN_DEB_BIT];
        pin_sel_reg             <= wdata_in[mcrb_pkg::PIN_SEL_BIT];
      end
      if (wr_wdog) begin
        watchdog_mode_select_reg    <= wdata_in[mcrb_pkg::WDOG_MODE_BIT];
        watchdog_timeout_select_reg <= wdata_in[mcrb_pkg::WDOG_TIME_LSB +: 3];
      end
      if (wr_batt)
        battery_threshold_code_reg <= wdata_in[mcrb_pkg::THR_LSB +: 5];
      if (wr_disch) begin
        discharge_threshold_code_reg  <= wdata_in[mcrb_pkg::THR_LSB +: 5];
        discharge_debounce_select_reg <= wdata_in[mcrb_pkg::DISCH_DEB_BIT];
      end
      if (wr_lamp) begin
        lamp_one_period_reg <= wdata_in[mcrb_pkg::LAMP1_LSB +: 3];
        lamp_two_period_reg <= wdata_in[mcrb_pkg::LAMP2_LSB +: 3];
      end
    end
  end

  // ==========================================================================
  // Slow ticks: 30.5 us, 1 ms and 50 ms, all one-cycle enables
  wire short_wrap = (short_cnt_reg == 32'(SHORT_TICK_CYC - 1));
  wire ms_wrap    = (ms_cnt_reg == 32'(MS_TICK_CYC - 1));
  wire long_wrap  = ms_wrap && (long_cnt_reg == 6'(mcrb_pkg::LONG_RATE_MS - 1));

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      short_cnt_reg  <= 32'h0;
      ms_cnt_reg     <= 32'h0;
      long_cnt_reg   <= 6'h0;
      short_tick_reg <= 1'b0;
      ms_tick_reg    <= 1'b0;
      long_tick_reg  <= 1'b0;
    end else begin
      short_cnt_reg  <= short_wrap ? 32'h0 : short_cnt_reg + 32'h1;
      ms_cnt_reg     <= ms_wrap ? 32'h0 : ms_cnt_reg + 32'h1;
      if (ms_wrap)
        long_cnt_reg <= long_wrap ? 6'h0 : long_cnt_reg + 6'h1;
      short_tick_reg <= short_wrap;
      ms_tick_reg    <= ms_wrap;
      long_tick_reg  <= long_wrap;
    end
  end

  // ==========================================================================
  // Debounced inputs: pin level and discharge comparator
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_deb
      mcrb_debounce #(
        .RESET_VAL    (g == 0 ? mcrb_pkg::PIN_STS_RST : mcrb_pkg::DISCH_FLG_RST)
      ) u_deb (
        .mclk_in      (mclk_in),
        .rst_b_in     (rst_b_in),
        .sample_en_in (deb_sel[g] ? long_tick_reg : short_tick_reg),
        .level_in     (deb_raw[g]),
        .level_out    (deb_level[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Pin drive
  assign pin_oe_out              = pin_dir_reg;
  assign pin_out                 = pin_sel_reg ? pwm_in : pin_set_reg;
  assign pin_pulldown_enable_out = pin_pden_reg;

  // ==========================================================================
  // Comparators; bypass suppresses the discharge flag
  assign batt_thr_mv_out  = mcrb_pkg::thr_mv(battery_threshold_code_reg);
  assign disch_thr_mv_out = mcrb_pkg::thr_mv(discharge_threshold_code_reg);

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in)
      disch_reg <= mcrb_pkg::DISCH_FLG_RST;
    else
      disch_reg <= deb_level[1] && (discharge_threshold_code_reg != 5'h00);
  end
  assign discharge_below_out = disch_reg;

  // ==========================================================================
  // Watchdog; the counter advances on millisecond ticks
  wire [16:0] wdog_lim   = mcrb_pkg::wdog_ms(watchdog_timeout_select_reg);
  wire        wdog_on    = (wdog_lim != 17'd0);
  wire        wdog_exp   = wdog_on && ms_tick_reg && (wdog_cnt_reg >= wdog_lim - 17'd1);
  wire        per_mode   = !watchdog_mode_select_reg;
  wire        per_exp    = per_mode && wdog_exp;
  wire        pend_exp   = !per_mode && any_irq_pending_in && wdog_exp;
  wire        cnt_clear  = wr_wdog || !wdog_on || per_exp ||
                           (per_mode ? wdog_irq_clear_in : !any_irq_pending_in);

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      wdog_cnt_reg <= 17'h0;
      wdog_irq_reg <= 1'b0;
      shutdown_reg <= 1'b0;
    end else begin
      if (cnt_clear)
        wdog_cnt_reg <= 17'h0;
      else if (ms_tick_reg)
        wdog_cnt_reg <= wdog_cnt_reg + 17'h1;
      // A new period sets the flag even in the cycle it is cleared
      wdog_irq_reg <= per_exp || (wdog_irq_reg && !wdog_irq_clear_in);
      // Shutdown holds until reset since the supplies go away
      if ((per_exp && wdog_irq_reg && !wdog_irq_clear_in) || pend_exp)
        shutdown_reg <= 1'b1;
    end
  end
  assign wdog_irq_out          = wdog_irq_reg;
  assign watchdog_shutdown_out = shutdown_reg;

  // ==========================================================================
  // Lamp period generators
  wire [2:0] lamp_code [2];
  assign lamp_code[0] = lamp_one_period_reg;
  assign lamp_code[1] = lamp_two_period_reg;

  generate
    for (g = 0; g < 2; g++) begin : g_lamp
      wire [12:0] lim  = mcrb_pkg::lamp_ms(lamp_code[g]);
      wire        wrap = ms_tick_reg && (lim != 13'd0) && (lamp_cnt_reg[g] >= lim - 13'd1);
      always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
          lamp_cnt_reg[g]  <= 13'h0;
          lamp_tick_reg[g] <= 1'b0;
        end else begin
          if (wr_lamp || wrap || lim == 13'd0)
            lamp_cnt_reg[g] <= 13'h0;
          else if (ms_tick_reg)
            lamp_cnt_reg[g] <= lamp_cnt_reg[g] + 13'h1;
          lamp_tick_reg[g] <= wrap && !wr_lamp;
        end
      end
    end
  endgenerate
  assign lamp_period_tick_out = lamp_tick_reg;
  assign rdata_out            = rdata_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  pin_src_a: assert property (pin_oe_out |-> pin_out == (pin_sel_reg ? pwm_in : pin_set_reg))
    else $error("pin output source wrong");
  pin_dir_a: assert property (wr_pin |=> pin_oe_out == $past(wdata_in[mcrb_pkg::PIN_DIR_BIT]))
    else $error("pin direction not written");
  pulldown_a: assert property (wr_pin |=> pin_pulldown_enable_out == $past(wdata_in[mcrb_pkg::PIN_PDEN_BIT]))
    else $error("pulldown not following its bit");
  sts_read_a: assert property (rd_in && addr_in == mcrb_pkg::PIN_CFG_OFS |=>
    rdata_out[mcrb_pkg::PIN_STS_BIT] == $past(pin_sts)) else $error("pin status read wrong");
  deb_hold_a: assert property ($changed(pin_sts) |-> $past(deb_raw[0], 2) == pin_sts)
    else $error("pin status changed without samples");
  wdog_per_a: assert property (per_exp |=> wdog_irq_out)
    else $error("periodic interrupt missing");
  wdog_sd_a: assert property (per_exp && wdog_irq_reg && !wdog_irq_clear_in |=> watchdog_shutdown_out)
    else $error("missed periodic shutdown");
  wdog_pend_a: assert property (pend_exp |=> watchdog_shutdown_out)
    else $error("pending interrupt shutdown missing");
  wdog_off_a: assert property (watchdog_timeout_select_reg == 3'h0 |-> !wdog_exp)
    else $error("disabled watchdog expired");
  bypass_a: assert property (discharge_threshold_code_reg == 5'h00 |=> !discharge_below_out)
    else $error("bypassed comparator flagged");
  thr_a: assert property (battery_threshold_code_reg == 5'h0E |-> batt_thr_mv_out == 12'd3000)
    else $error("threshold mapping wrong");
  lamp_off_a: assert property (lamp_one_period_reg == 3'h0 |=> !lamp_period_tick_out[0])
    else $error("lamp off still ticks");
  rst_wr_a: assert property (wr_lamp |=> lamp_cnt_reg[0] == 13'h0)
    else $error("lamp counter not restarted");

  per_irq_c:  cover property (per_exp ##1 wdog_irq_out);
  shutdown_c: cover property ($rose(watchdog_shutdown_out));
  lamp_c:     cover property (lamp_period_tick_out[1]);
endmodule // mcrb_top

// >>> verif/test_misc_control_register_bank.sv
// Self-checking bench for the misc control register bank
`timescale 1ns/1ps
module test_misc_control_register_bank;
  // ==========================================================================
  // Signals
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [7:0]  rdata_out;
  logic        pin_in = 1'b1;
  logic        pin_out;
  logic        pin_oe_out;
  logic        pin_pd_out;
  logic        pwm_in = 1'b0;
  logic        irq_clr = 1'b0;
  logic        irq_pend = 1'b0;
  logic        wdog_irq_out;
  logic        shutdown_out;
  logic        disch_raw = 1'b0;
  logic [11:0] batt_mv_out;
  logic [11:0] disch_mv_out;
  logic        below_out;
  logic [1:0]  lamp_tick_out;
  int          err_count = 0;
  int          samples_checked = 0;
  // Small tick counts keep the long ms timeouts inside the run budget
  localparam int MS_CYC = 2;
  logic [4:0]  thr_code [8] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h0E, 5'h17, 5'h18, 5'h1F};
  logic [11:0] thr_mv   [8] = '{12'h000, 12'h9C4, 12'h9C4, 12'h9F6, 12'hBB8, 12'hD7A, 12'hDAC, 12'hDAC};
  logic [7:0]  rst_val  [6] = '{8'h0A, 8'h01, 8'h1C, 8'h00, 8'h00, 8'h00};
  logic [7:0]  rv;
  always #2 mclk_in = ~mclk_in;
  mcrb_top #(.SHORT_TICK_CYC(4), .MS_TICK_CYC(MS_CYC)) u_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .boot_wdog_time_in(3'h1), .boot_batt_thr_in(5'h0E),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_pulldown_enable_out(pin_pd_out),
    .pwm_in(pwm_in), .wdog_irq_clear_in(irq_clr), .any_irq_pending_in(irq_pend), .wdog_irq_out(wdog_irq_out),
    .watchdog_shutdown_out(shutdown_out), .discharge_raw_in(disch_raw), .batt_thr_mv_out(batt_mv_out),
    .disch_thr_mv_out(disch_mv_out), .discharge_below_out(below_out), .lamp_period_tick_out(lamp_tick_out));
  // ==========================================================================
  // Tasks
  task automatic note(input bit ok, input string what);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    note(got === exp, what);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    note(got === exp, what);
  endtask
  task automatic chk_mv(input logic [11:0] got, input logic [11:0] exp, input string what);
    note(got === exp, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic measure(input int b, input int exp_cyc);
    int n;
    n = 0;
    while (lamp_tick_out[b] !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    n = 1;
    cyc(1);
    while (lamp_tick_out[b] !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk_mv(12'(n), 12'(exp_cyc), "lamp period");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    #400000;
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run();
  end
  initial begin
    cyc(16);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd((i < 5) ? 8'(8'h68 + i) : 8'h70, rv);
      chk_reg(rv, rst_val[i], "reset value");
    end
    chk_bit(pin_pd_out, 1'b1, "pulldown after reset");
    chk_bit(pin_oe_out, 1'b0, "direction after reset");
    wr(8'h69, 8'h00);
    wr(8'h70, 8'hFF);
    rd(8'h70, rv);
    chk_reg(rv, 8'h00, "unmapped read");
    $display("test reset done");
    wr(8'h68, 8'hFF);
    rd(8'h68, rv);
    chk_reg(rv, 8'h3F, "pin config readback");
    pwm_in <= 1'b1;
    cyc(1);
    chk_bit(pin_out, 1'b1, "pwm high");
    pwm_in <= 1'b0;
    cyc(1);
    chk_bit(pin_out, 1'b0, "pwm low");
    chk_bit(pin_oe_out, 1'b1, "output mode");
    wr(8'h68, 8'h05);
    chk_bit(pin_out, 1'b1, "software value");
    chk_bit(pin_pd_out, 1'b0, "pulldown off");
    wr(8'h68, 8'h04);
    chk_bit(pin_out, 1'b0, "software value low");
    wr(8'h68, 8'h00);
    chk_bit(pin_oe_out, 1'b0, "input mode");
    pin_in <= 1'b0;
    cyc(3);
    pin_in <= 1'b1;
    cyc(20);
    rd(8'h68, rv);
    chk_reg(rv, 8'h02, "glitch ignored");
    pin_in <= 1'b0;
    cyc(20);
    rd(8'h68, rv);
    chk_reg(rv, 8'h00, "short debounce");
    wr(8'h68, 8'h10);
    pin_in <= 1'b1;
    cyc(150);
    rd(8'h68, rv);
    chk_reg(rv, 8'h10, "long debounce pending");
    cyc(240);
    rd(8'h68, rv);
    chk_reg(rv, 8'h12, "long debounce done");
    $display("test pin done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h6A, {2'h0, thr_code[i], 1'h0});
      chk_mv(batt_mv_out, thr_mv[i], "battery threshold");
      wr(8'h6B, {2'h0, thr_code[i], 1'h0});
      chk_mv(disch_mv_out, thr_mv[i], "discharge threshold");
    end
    wr(8'h6B, 8'h0A);
    disch_raw <= 1'b1;
    cyc(20);
    chk_bit(below_out, 1'b1, "discharge flagged");
    wr(8'h6B, 8'h0B);
    rd(8'h6B, rv);
    chk_reg(rv, 8'h0B, "discharge readback");
    disch_raw <= 1'b0;
    cyc(150);
    chk_bit(below_out, 1'b1, "discharge long pending");
    cyc(240);
    chk_bit(below_out, 1'b0, "discharge long done");
    disch_raw <= 1'b1;
    wr(8'h6B, 8'h00);
    cyc(20);
    chk_bit(below_out, 1'b0, "discharge bypass");
    $display("test comparators done");
    wr(8'h6C, 8'hD1);
    rd(8'h6C, rv);
    chk_reg(rv, 8'h11, "lamp readback");
    measure(0, 125 * MS_CYC);
    measure(1, 250 * MS_CYC);
    $display("test lamps done");
    wr(8'h69, 8'hFF);
    rd(8'h69, rv);
    chk_reg(rv, 8'h0F, "watchdog readback");
    irq_clr <= 1'b1;
    irq_pend <= 1'b1;
    wr(8'h69, 8'h09);
    irq_clr <= 1'b0;
    cyc(4900 * MS_CYC);
    chk_bit(shutdown_out, 1'b0, "no early shutdown");
    for (int n = 0; n < 300 * MS_CYC && shutdown_out !== 1'b1; n++)
      cyc(1);
    chk_bit(shutdown_out, 1'b1, "pending shutdown");
    $display("test watchdog done");
    // Only reset lifts a shutdown; reset restores periodic mode and the boot code its 5000 ms timeout
    irq_pend <= 1'b0;
    rst_b_in <= 1'b0;
    cyc(16);
    rst_b_in <= 1'b1;
    cyc(2);
    chk_bit(shutdown_out, 1'b0, "shutdown after reset");
    chk_bit(wdog_irq_out, 1'b0, "irq after reset");
    cyc(4990 * MS_CYC);
    chk_bit(wdog_irq_out, 1'b0, "no early irq");
    for (int n = 0; n < 20 * MS_CYC && wdog_irq_out !== 1'b1; n++)
      cyc(1);
    chk_bit(wdog_irq_out, 1'b1, "periodic irq");
    irq_clr <= 1'b1;
    cyc(1);
    irq_clr <= 1'b0;
    cyc(1);
    chk_bit(wdog_irq_out, 1'b0, "irq cleared");
    for (int n = 0; n < 5010 * MS_CYC && wdog_irq_out !== 1'b1; n++)
      cyc(1);
    chk_bit(wdog_irq_out, 1'b1, "second periodic irq");
    chk_bit(shutdown_out, 1'b0, "cleared irq spares");
    for (int n = 0; n < 5010 * MS_CYC && shutdown_out !== 1'b1; n++)
      cyc(1);
    chk_bit(shutdown_out, 1'b1, "periodic shutdown");
    $display("test periodic done");
    complete_run();
  end
endmodule // test_misc_control_register_bank
